// *** hdl/close_onto_fault_guard_map.svh ***
`ifndef CLOSE_ONTO_FAULT_GUARD_MAP_SVH
`define CLOSE_ONTO_FAULT_GUARD_MAP_SVH
// release time default in ms, and clock rate in kHz
`define GUARD_RELEASE_DEFAULT_MS 21'd1000
`define GUARD_CLK_KHZ 32'd10000
// cycles per millisecond tick
`define GUARD_MS_CYCLES (`GUARD_CLK_KHZ)
`define GUARD_LOG_DEPTH 12
`define GUARD_MODE_RESET 3'h0
`define GUARD_FORCE_RESET 2'h0
`endif

// *** hdl/close_onto_fault_guard_pkg.sv ***
package close_onto_fault_guard_pkg;
  typedef enum logic [2:0] {
    MODE_ON, MODE_BLOCKED, MODE_TEST, MODE_TEST_BLOCKED, MODE_OFF
  } node_operating_mode_t;
  typedef enum logic [1:0] {
    FORCE_NORMAL, FORCE_BLOCKED, FORCE_ACTIVE, FORCE_TRIP
  } forced_status_select_t;
  typedef enum logic [2:0] {
    COND_NORMAL, COND_INIT, COND_ACTIVE, COND_TRIP, COND_BLOCKED
  } guard_condition_state_t;
  // event index: 0 init, 1 block, 2 active, 3 trip
  typedef struct packed {
    logic [31:0] stamp_ms;
    logic [1:0] event_id;
    logic on_not_off;
  } guard_event_t;
  typedef struct packed {
    logic [31:0] stamp_ms;
    logic [2:0] active_setting_group;
    logic [20:0] remaining_ms;
    logic [20:0] elapsed_ms;
  } guard_log_t;
endpackage

// *** hdl/close_onto_fault_guard.sv ***
`timescale 1ns/1ps
`include "close_onto_fault_guard_map.svh"
// What this block does
// - window arms on rising edge of activate input, never on level.
// - trip asserts at once when a function input is active in window.
// - block input keeps the window from starting.
// - window lasts configurable release time, default one second.
// - release time may change via setting group while running.
// - node operating mode On, Blocked, Test, Test/Blocked, Off; resets On.
// - forced status Normal, Blocked, Active, Trip overrides; default Normal.
// - readable condition status: Normal, Active, Trip, Blocked; Init is always outranked by Active or Blocked.
// - separate ON and OFF events per state, each storable by enable.
// - every event carries a time stamp.
// - cumulative counters for init, blocked, active, trip; clearable.
// - activation ON events logged into last twelve records.
// - record holds stamp, setting group, remaining, elapsed.
module close_onto_fault_guard
  import close_onto_fault_guard_pkg::*;
#(
  parameter int MS_CYCLES = `GUARD_MS_CYCLES,
  parameter int FCN_WIDTH = 4,
  parameter int LOG_DEPTH = `GUARD_LOG_DEPTH
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // binary inputs from pins and stages
  input wire logic i_activate,
  input wire logic i_block,
  input wire logic [FCN_WIDTH-1:0] i_function,
  // settings
  input wire logic [20:0] i_release_window_time,
  input wire logic [2:0] i_active_setting_group,
  input wire node_operating_mode_t i_node_operating_mode,
  input wire forced_status_select_t i_forced_status_select,
  input wire logic [3:0] i_event_on_enable,
  input wire logic [3:0] i_event_off_enable,
  input wire logic i_counter_clear,
  input wire logic [3:0] i_log_index,
  // outputs
  output logic o_active,
  output logic o_trip,
  output logic o_blocked,
  output guard_condition_state_t o_guard_condition_state,
  output logic o_event_valid,
  output guard_event_t o_event,
  output logic [15:0] o_count_init,
  output logic [15:0] o_count_blocked,
  output logic [15:0] o_count_active,
  output logic [15:0] o_count_trip,
  output guard_log_t o_log_record,
  output logic [3:0] o_log_count
);

  // ********************
  // input synchronisers
  // ********************
  logic [FCN_WIDTH+1:0] sync1, sync2;
  logic act_prev;
  logic act_s, blk_s, fcn_any;
  assign act_s = sync2[0];
  assign blk_s = sync2[1];
  assign fcn_any = |sync2[FCN_WIDTH+1:2];

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1 <= '0;
      sync2 <= '0;
      act_prev <= 1'b0;
    end else begin
      sync1 <= {i_function, i_block, i_activate};
      sync2 <= sync1;
      act_prev <= act_s;
    end
  end

  // ********************
  // window and timing
  // ********************
  logic [31:0] div, next_div;
  logic [31:0] now_ms, next_now_ms;
  logic [20:0] elapsed, next_elapsed;
  logic window, next_window;
  logic next_tripped;
  logic ms_tick, rise, blk_eff, test_mode, off_mode;
  logic [20:0] remaining;

  // a mode of Blocked counts as a block; Off closes the window, clears elapsed and stops init and trip
  assign off_mode = (i_node_operating_mode == MODE_OFF);
  assign test_mode = (i_node_operating_mode == MODE_TEST) ||
                     (i_node_operating_mode == MODE_TEST_BLOCKED);
  assign blk_eff = blk_s || (i_node_operating_mode == MODE_BLOCKED) ||
                   (i_node_operating_mode == MODE_TEST_BLOCKED) ||
                   (i_forced_status_select == FORCE_BLOCKED);
  assign ms_tick = (div == 32'(MS_CYCLES - 1));
  assign rise = act_s && !act_prev;
  // live setting read each cycle, so a group change takes effect at once;
  // next value used so a restart never logs the old window's elapsed time
  assign remaining = (i_release_window_time > next_elapsed) ?
                     (i_release_window_time - next_elapsed) : 21'h0;

  always_comb begin
    next_div = ms_tick ? 32'h0 : div + 32'h1;
    next_now_ms = ms_tick ? now_ms + 32'h1 : now_ms;
    next_window = window;
    next_elapsed = elapsed;
    if (off_mode) begin
      next_window = 1'b0;
      next_elapsed = 21'h0;
    end else if (rise && !blk_eff) begin
      next_window = 1'b1;
      next_elapsed = 21'h0;
    end else if (window) begin
      if (ms_tick) begin
        next_elapsed = elapsed + 21'h1;
      end
      if (ms_tick && (elapsed + 21'h1 >= i_release_window_time)) begin
        next_window = 1'b0;
      end
    end
    next_tripped = !off_mode && window && fcn_any && !test_mode;
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div <= 32'h0;
      now_ms <= 32'h0;
      elapsed <= 21'h0;
      window <= 1'b0;
    end else begin
      div <= next_div;
      now_ms <= next_now_ms;
      elapsed <= next_elapsed;
      window <= next_window;
    end
  end

  // ********************
  // status, events, counters
  // ********************
  logic [3:0] state_now, state_prev;
  logic [3:0] on_ev, off_ev;
  logic [1:0] ev_pick;
  logic ev_hit, ev_on;
  guard_condition_state_t next_cond;
  logic [15:0] next_cnt [4];
  logic [15:0] cnt [4];

  always_comb begin
    state_now[0] = rise && !off_mode; // init: activate edge seen
    state_now[1] = blk_eff;
    state_now[2] = next_window;
    state_now[3] = next_tripped;
    case (i_forced_status_select)
      FORCE_ACTIVE: state_now[2] = 1'b1;
      FORCE_TRIP: state_now[3] = 1'b1;
      default: ;
    endcase
    on_ev = state_now & ~state_prev;
    off_ev = ~state_now & state_prev;
    ev_hit = 1'b0;
    ev_on = 1'b0;
    ev_pick = 2'h0;
    // one event per cycle; higher index wins when several coincide
    for (int k = 0; k < 4; k++) begin
      if (on_ev[k] && i_event_on_enable[k]) begin
        ev_hit = 1'b1;
        ev_on = 1'b1;
        ev_pick = 2'(k);
      end else if (off_ev[k] && i_event_off_enable[k]) begin
        ev_hit = 1'b1;
        ev_on = 1'b0;
        ev_pick = 2'(k);
      end
    end
    for (int k = 0; k < 4; k++) begin
      next_cnt[k] = i_counter_clear ? 16'h0 : cnt[k];
      if (on_ev[k]) begin
        next_cnt[k] = next_cnt[k] + 16'h1;
      end
    end
    if (state_now[3]) next_cond = COND_TRIP;
    else if (state_now[1]) next_cond = COND_BLOCKED;
    else if (state_now[2]) next_cond = COND_ACTIVE;
    else if (state_now[0]) next_cond = COND_INIT;
    else next_cond = COND_NORMAL;
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_prev <= 4'h0;
      o_event_valid <= 1'b0;
      o_event <= '0;
      o_guard_condition_state <= COND_NORMAL;
      o_active <= 1'b0;
      o_trip <= 1'b0;
      o_blocked <= 1'b0;
      for (int k = 0; k < 4; k++) cnt[k] <= 16'h0;
    end else begin
      state_prev <= state_now;
      o_event_valid <= ev_hit;
      o_event <= '{stamp_ms: now_ms, event_id: ev_pick,
                  on_not_off: ev_on};
      o_guard_condition_state <= next_cond;
      o_active <= state_now[2];
      o_trip <= state_now[3];
      o_blocked <= state_now[1];
      for (int k = 0; k < 4; k++) cnt[k] <= next_cnt[k];
    end
  end
  assign o_count_init = cnt[0];
  assign o_count_blocked = cnt[1];
  assign o_count_active = cnt[2];
  assign o_count_trip = cnt[3];

  // ********************
  // operation log
  // ********************
  guard_log_t log_mem [LOG_DEPTH];
  logic [3:0] wr_ptr, next_wr_ptr, next_log_count;
  logic [3:0] rd_ptr;
  logic [4:0] rd_sum;
  logic log_wr;

  // record taken when the active state turns on
  assign log_wr = on_ev[2];
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_log_count = o_log_count;
    // five bits so the sum cannot wrap before the modulo while i_log_index stays below LOG_DEPTH
    rd_sum = 5'(wr_ptr) + 5'(LOG_DEPTH) - 5'h1 - 5'(i_log_index);
    rd_ptr = 4'(rd_sum % 5'(LOG_DEPTH));
    if (log_wr) begin
      next_wr_ptr = (wr_ptr == 4'(LOG_DEPTH - 1)) ? 4'h0 : wr_ptr + 4'h1;
      if (o_log_count != 4'(LOG_DEPTH)) next_log_count = o_log_count + 4'h1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_ptr <= 4'h0;
      o_log_count <= 4'h0;
      o_log_record <= '0;
      for (int k = 0; k < LOG_DEPTH; k++) log_mem[k] <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      o_log_count <= next_log_count;
      if (log_wr) begin
        log_mem[wr_ptr] <= '{stamp_ms: now_ms,
                             active_setting_group: i_active_setting_group,
                             remaining_ms: remaining,
                             elapsed_ms: next_elapsed};
      end
      // index 0 is the newest record
      o_log_record <= log_mem[rd_ptr];
    end
  end

  // ********************
  // checks
  // ********************
  sequence s_edge_free;
    rise && !blk_eff && !off_mode;
  endsequence
  a_window_arms: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    s_edge_free |=> window) else $error("window not armed");
  a_level_only: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    (!window && !rise && !off_mode) |=> !window)
    else $error("window armed by level");
  a_trip_fast: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    (window && fcn_any && !test_mode && !off_mode &&
     i_forced_status_select == FORCE_NORMAL) |=> o_trip)
    else $error("trip late");
  a_block_holds: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    (!window && blk_eff) |=> !window) else $error("blocked start");
  a_window_ends: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    (window && ms_tick && !rise && elapsed + 21'h1 >= i_release_window_time)
    |=> !window) else $error("window overran");
  a_trip_clears: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    (!window && i_forced_status_select == FORCE_NORMAL) |=> !o_trip)
    else $error("trip stuck");
  a_mode_reset: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    $rose(i_arst_n) |-> !window && !o_trip) else $error("reset state");
  a_log_bound: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    o_log_count <= 4'(LOG_DEPTH)) else $error("log overfull");
  a_count_clear: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    (i_counter_clear && !on_ev[3]) |=> cnt[3] == 16'h0)
    else $error("counter not cleared");
endmodule // close_onto_fault_guard

// *** bench/stage_model.sv ***
`timescale 1ns/1ps
module stage_model (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // requests from the bench
  input wire logic i_close_req,
  input wire logic [3:0] i_start_req,
  // lines toward the guard
  output logic o_activate,
  output logic [3:0] o_function
);
  // close command or pin arms the guard; stages raise starts
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_activate <= 1'b0;
      o_function <= 4'h0;
    end else begin
      o_activate <= i_close_req;
      o_function <= i_start_req;
    end
  end
endmodule // stage_model

// *** bench/close_onto_fault_guard_test.sv ***
`timescale 1ns/1ps
module close_onto_fault_guard_test;
  import close_onto_fault_guard_pkg::*;
  logic i_ref_clk = 1'b0, i_arst_n = 1'b0, close_req = 1'b0, blk = 1'b0;
  logic clr = 1'b0;
  logic [3:0] start_req = 4'h0, idx = 4'h0;
  logic [20:0] rel = 21'h5;
  logic [2:0] sg = 3'h5;
  node_operating_mode_t mode = MODE_ON;
  forced_status_select_t frc = FORCE_NORMAL;
  logic act, o_active, o_trip, o_blocked, o_event_valid;
  logic [3:0] fcn, o_log_count;
  guard_condition_state_t cond;
  guard_event_t ev, ev_last;
  logic [15:0] c_init, c_blk, c_act, c_trip;
  guard_log_t rec;
  int fail_count = 0, checks_done = 0, cyc = 0, ev_seen = 0, n;
  always #50 i_ref_clk = ~i_ref_clk;
  stage_model stage_model_inst (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
    .i_close_req(close_req), .i_start_req(start_req), .o_activate(act),
    .o_function(fcn));
  close_onto_fault_guard #(.MS_CYCLES(10)) close_onto_fault_guard_inst (
    .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_activate(act),
    .i_block(blk), .i_function(fcn), .i_release_window_time(rel),
    .i_active_setting_group(sg), .i_node_operating_mode(mode),
    .i_forced_status_select(frc), .i_event_on_enable(4'hF),
    .i_event_off_enable(4'hF), .i_counter_clear(clr), .i_log_index(idx),
    .o_active(o_active), .o_trip(o_trip), .o_blocked(o_blocked),
    .o_guard_condition_state(cond), .o_event_valid(o_event_valid),
    .o_event(ev), .o_count_init(c_init), .o_count_blocked(c_blk),
    .o_count_active(c_act), .o_count_trip(c_trip), .o_log_record(rec),
    .o_log_count(o_log_count));
  // ****************
  // helpers
  // ****************
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge i_ref_clk);
  endtask
  // rise on close line; stage, sync and output registers take about four edges
  task automatic arm();
    @(posedge i_ref_clk) close_req <= 1'b0;
    tick(2);
    close_req <= 1'b1;
    tick(7);
  endtask
  task automatic wait_idle();
    n = 0;
    while (o_active === 1'b1 && n < 600) begin
      @(posedge i_ref_clk);
      n++;
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge i_ref_clk) begin
    cyc++;
    if (o_event_valid === 1'b1) begin
      ev_seen++;
      ev_last = ev;
    end
    if (cyc == 30000) begin
      fail_count++;
      final_report();
    end
  end
  // ****************
  // scenarios
  // ****************
  task automatic t_window();
    arm();
    chk("active", o_active, 1);
    wait_idle();
    chk("len", (n >= 35 && n <= 52), 1);
    start_req <= 4'h1;
    tick(8);
    chk("late_trip", o_trip, 0);
    chk("cnt_act", c_act, 1);
    chk("log_cnt", o_log_count, 1);
    chk("log_sg", rec.active_setting_group, 5);
    chk("events", ev_seen > 0, 1);
    chk("ev_last", {ev_last.event_id, ev_last.on_not_off}, 3'h4);
    chk("ev_stamp", ev_last.stamp_ms != 32'h0, 1'h1);
    chk("cnt_init", c_init, 16'h1);
    chk("log_rem", rec.remaining_ms, 21'h5);
    chk("log_elp", rec.elapsed_ms, 21'h0);
    start_req <= 4'h0;
    $display("window test done");
  endtask
  task automatic t_trip();
    arm();
    start_req <= 4'h4;
    tick(7);
    chk("trip", o_trip, 1);
    chk("cond", cond, COND_TRIP);
    start_req <= 4'h0;
    wait_idle();
    tick(4);
    chk("trip_clr", o_trip, 0);
    chk("cnt_trip", c_trip, 1);
    $display("trip test done");
  endtask
  task automatic t_modes();
    blk <= 1'b1;
    tick(4);
    arm();
    chk("blk_act", o_active, 0);
    chk("blk_out", o_blocked, 1);
    chk("cnt_blk", c_blk, 16'h1);
    blk <= 1'b0;
    mode <= MODE_OFF;
    arm();
    chk("off_act", o_active, 0);
    mode <= MODE_TEST;
    arm();
    start_req <= 4'h8;
    tick(7);
    chk("test_trip", o_trip, 0);
    start_req <= 4'h0;
    wait_idle();
    mode <= MODE_BLOCKED;
    arm();
    chk("mblk_act", o_active, 1'h0);
    mode <= MODE_TEST_BLOCKED;
    arm();
    chk("tblk_act", o_active, 1'h0);
    mode <= MODE_ON;
    frc <= FORCE_TRIP;
    tick(4);
    chk("frc_trip", o_trip, 1);
    frc <= FORCE_ACTIVE;
    tick(4);
    chk("frc_act", o_active, 1'h1);
    chk("frc_cond", cond, COND_ACTIVE);
    frc <= FORCE_BLOCKED;
    tick(4);
    chk("frc_blk", o_blocked, 1'h1);
    frc <= FORCE_NORMAL;
    tick(4);
    chk("frc_off", o_trip, 0);
    chk("frc_unblk", o_blocked, 1'h0);
    $display("mode test done");
  endtask
  task automatic t_live();
    rel <= 21'h32;
    arm();
    tick(10);
    rel <= 21'h2;
    wait_idle();
    chk("live", n < 35, 1);
    clr <= 1'b1;
    tick(2);
    clr <= 1'b0;
    tick(2);
    chk("clr", {c_init, c_act}, 0);
    chk("clr2", {c_blk, c_trip}, 32'h0);
    rel <= 21'h1;
    repeat (13) begin
      arm();
      wait_idle();
    end
    chk("log_sat", o_log_count, 4'hC);
    chk("log_rem1", rec.remaining_ms, 21'h1);
    chk("log_elp1", rec.elapsed_ms, 21'h0);
    $display("live and log test done");
  endtask
  initial begin
    tick(4);
    i_arst_n <= 1'b1;
    tick(2);
    chk("rst_cond", cond, COND_NORMAL);
    t_window();
    t_trip();
    t_modes();
    t_live();
    final_report();
  end
endmodule // close_onto_fault_guard_test
